// file: hw/modbus_tcp_data_area_server.v
// Modbus-TCP request interpreter serving the 1 KiB gateway data buffer.
`timescale 1ns/1ns
//
// Summary of operation
// - Only answers requests from a master; never starts an exchange itself.
// - No exchange unless both input and output sizes are nonzero.
// - Accepts connections on TCP port 502, at most eight at once.
// - Function unsupported in the active mode answers exception 0x01.
// - Range outside the configured buffer part answers exception 0x02.
// - Illegal quantity or data values answer exception 0x03.
// - Standard and flexible modes; flexible mode after reset.
// - Standard mode offers no coil or discrete access.
// - Standard mode functions 3, 6, 16, 22, 23 use the output area.
// - Standard mode function 4 reads the input area only.
// - Standard register n maps to byte 2*(n-1) from 0x000 or 0x200.
// - Flexible reads: 1-2000 bits, 1-125 registers, either area.
// - Flexible writes hit output area only, with per-function limits.
// - Flexible function 23 reads up to 125, writes up to 100 registers.
// - Flexible map: 1-256 input, 257-1024 reserved, 1025-1280 output.
// - All flexible functions share one register and coil numbering.
// - Coils run MSB first; first coil is register bit 15.
// - Coil writes change single bits, leaving the other bits intact.
`include "modbus_server_defines.vh"

module modbus_tcp_data_area_server #(
  parameter [3:0] MAX_CONN = `MAX_CONN
) (
  input  wire       i_clk,
  input  wire       i_reset,
  input  wire       i_cfg_wr,
  input  wire       i_cfg_std_mode,
  input  wire [9:0] i_in_size,
  input  wire [9:0] i_out_size,
  input  wire       i_conn_open,
  input  wire [15:0] i_conn_port,
  input  wire       i_conn_close,
  output reg        o_conn_accept,
  output reg        o_conn_refuse,
  output reg  [3:0] o_conn_count,
  input  wire       i_req_valid,
  input  wire [7:0] i_req_data,
  input  wire       i_req_last,
  input  wire [2:0] i_req_conn,
  output reg        o_req_ready,
  output reg        o_rsp_valid,
  output reg  [7:0] o_rsp_data,
  output reg        o_rsp_last,
  output reg  [2:0] o_rsp_conn,
  input  wire       i_rsp_ready,
  input  wire       i_buf_we,
  input  wire [9:0] i_buf_addr,
  input  wire [7:0] i_buf_wdata,
  output reg  [7:0] o_buf_rdata,
  output reg        o_std_mode,
  output reg        o_exchange_on
);

  localparam [4:0] S_COL = 5'b00001;
  localparam [4:0] S_CHK = 5'b00010;
  localparam [4:0] S_WR  = 5'b00100;
  localparam [4:0] S_DRN = 5'b01000;
  localparam [4:0] S_RSP = 5'b10000;

  reg  [7:0]  gateway_data_buffer [0:1023];
  reg  [7:0]  hb [0:9];
  reg  [4:0]  st_r;
  reg  [4:0]  st_nxt;
  reg  [3:0]  hcnt_r;
  reg         last_r;
  reg         silent_r;
  reg         exc_r;
  reg  [7:0]  exc_code_r;
  reg  [8:0]  rsp_len_r;
  reg  [8:0]  idx_r;
  reg  [21:0] cur_r;
  reg  [15:0] rem_r;
  reg  [21:0] rd_first_r;
  reg  [15:0] rd_bits_r;
  reg         wk_r;

  wire [7:0]  fc = hb[0];
  wire [15:0] ad = {hb[1], hb[2]};
  wire [15:0] qt = {hb[3], hb[4]};
  wire [15:0] wa = {hb[5], hb[6]};
  wire [15:0] wq = {hb[7], hb[8]};
  wire        std = o_std_mode;
  wire        is_coil = (fc == `FC_RD_COILS) || (fc == `FC_RD_DISC) ||
                        (fc == `FC_WR_COIL) || (fc == `FC_WR_COILS);
  wire        is_rd = (fc == `FC_RD_COILS) || (fc == `FC_RD_DISC) ||
                      (fc == `FC_RD_HOLD) || (fc == `FC_RD_INPUT) || (fc == `FC_RD_WR);
  wire        is_stream = (fc == `FC_WR_COILS) || (fc == `FC_WR_REGS) || (fc == `FC_RD_WR);
  wire        req_take = i_req_valid && o_req_ready;
  wire        rsp_load = (st_r == S_RSP) && (!o_rsp_valid || i_rsp_ready);

  function [3:0] hlen_of(input [7:0] f);
    begin
      case (f)
        `FC_WR_COILS, `FC_WR_REGS: hlen_of = `HLEN_MULTI;
        `FC_MASK_WR:               hlen_of = `HLEN_MASK;
        `FC_RD_WR:                 hlen_of = `HLEN_RW;
        `FC_RD_COILS, `FC_RD_DISC, `FC_RD_HOLD, `FC_RD_INPUT,
        `FC_WR_COIL, `FC_WR_REG:   hlen_of = `HLEN_BASIC;
        default:                   hlen_of = 4'h1;
      endcase
    end
  endfunction

  function [7:0] rev8(input [7:0] b);
    integer n;
    begin
      for (n = 0; n < 8; n = n + 1) begin
        rev8[n] = b[7-n];
      end
    end
  endfunction

  // The whole span must sit inside one configured area; the reserved hole fails both.
  function rng_ok(input [21:0] first, input [15:0] nbits, input ain, input aout);
    reg [21:0] lastb;
    begin
      lastb  = first + {6'h00, nbits} - 22'h00_0001;
      rng_ok = (ain && (lastb[21:3] < {9'h000, i_in_size})) ||
               (aout && (first[21:3] >= `OUT_BYTE_BASE) &&
                (lastb[21:3] < `OUT_BYTE_BASE + {9'h000, i_out_size}));
    end
  endfunction

  // Request checking, all from the held header bytes.
  reg        sup;
  reg        vbad;
  reg        abad;
  reg [21:0] base;
  reg [21:0] rd_first;
  reg [21:0] wr_first;
  reg [15:0] rd_bits;
  reg [15:0] wr_bits;
  reg [15:0] cbytes;
  reg [8:0]  len_ok;

  always @* begin
    cbytes = (qt + 16'h0007) >> 3;
    sup = (fc == `FC_RD_HOLD) || (fc == `FC_RD_INPUT) || (fc == `FC_WR_REG) ||
          (fc == `FC_WR_REGS) || (fc == `FC_MASK_WR) || (fc == `FC_RD_WR) ||
          (!std && ((fc == `FC_RD_COILS) || (fc == `FC_RD_DISC) ||
                    (fc == `FC_WR_COIL) || (fc == `FC_WR_COILS)));
    base = (std && (fc != `FC_RD_INPUT)) ? `OUT_BIT_BASE : 22'h00_0000;
    rd_first = is_coil ? {6'h00, ad} : base + {2'b00, ad, 4'h0};
    wr_first = (fc == `FC_RD_WR) ? base + {2'b00, wa, 4'h0} : rd_first;
    rd_bits  = is_coil ? qt : {qt[11:0], 4'h0};
    case (fc)
      `FC_WR_COIL:  wr_bits = 16'h0001;
      `FC_WR_COILS: wr_bits = qt;
      `FC_WR_REGS:  wr_bits = {qt[11:0], 4'h0};
      `FC_RD_WR:    wr_bits = {wq[11:0], 4'h0};
      default:      wr_bits = 16'h0010;
    endcase
    case (fc)
      `FC_RD_COILS, `FC_RD_DISC: vbad = (qt == 16'h0000) || (qt > `MAX_RD_BITS);
      `FC_RD_HOLD, `FC_RD_INPUT: vbad = (qt == 16'h0000) || (qt > `MAX_RD_REGS);
      `FC_WR_COIL:  vbad = (qt != `COIL_ON) && (qt != 16'h0000);
      `FC_WR_COILS: vbad = (qt == 16'h0000) || (qt > `MAX_WR_BITS) ||
                           ({8'h00, hb[5]} != cbytes);
      `FC_WR_REGS:  vbad = (qt == 16'h0000) || (qt > `MAX_WR_REGS) ||
                           ({8'h00, hb[5]} != {qt[14:0], 1'b0});
      `FC_RD_WR:    vbad = (qt == 16'h0000) || (qt > `MAX_RD_REGS) || (wq == 16'h0000) ||
                           (wq > `MAX_RW_WREGS) || ({8'h00, hb[9]} != {wq[14:0], 1'b0});
      default:      vbad = 1'b0;
    endcase
    vbad = vbad || (hcnt_r < hlen_of(fc));
    abad = (is_rd && !rng_ok(rd_first, rd_bits, !std || (fc == `FC_RD_INPUT),
                             !std || (fc != `FC_RD_INPUT))) ||
           (!is_rd || (fc == `FC_RD_WR)) && !rng_ok(wr_first, wr_bits, 1'b0, 1'b1);
    if (!is_rd) begin
      len_ok = (fc == `FC_MASK_WR) ? 9'h006 : 9'h004;
    end else if (is_coil) begin
      len_ok = 9'h001 + cbytes[8:0];
    end else begin
      len_ok = 9'h001 + {qt[7:0], 1'b0};
    end
  end

  // Bit datapath over two neighbouring buffer bytes at the cursor.
  wire [18:0] p0 = cur_r[21:3];
  wire [18:0] p1 = p0 + 19'h0_0001;
  wire [2:0]  sh = cur_r[2:0];
  wire [9:0]  a0 = {p0[11], p0[8:0]};
  wire [9:0]  a1 = {p1[11], p1[8:0]};
  wire [15:0] w = {gateway_data_buffer[a0], gateway_data_buffer[a1]};
  wire [3:0]  nb = (rem_r >= 16'h0008) ? 4'h8 : rem_r[3:0];
  wire [15:0] ws = w << sh;
  reg  [7:0]  src;
  reg  [7:0]  e_in;
  reg  [7:0]  e_rd;
  reg  [15:0] w_new;
  integer     i;
  integer     k;

  always @* begin
    if (is_stream) begin
      src = i_req_data;
    end else if (fc == `FC_WR_COIL) begin
      src = {7'h00, hb[3][0]};
    end else if (fc == `FC_WR_REG) begin
      src = wk_r ? hb[4] : hb[3];
    end else begin
      src = (w[15:8] & (wk_r ? hb[4] : hb[3])) | ((wk_r ? hb[6] : hb[5]) & ~(wk_r ? hb[4] : hb[3]));
    end
    e_in  = is_coil ? src : rev8(src);
    w_new = w;
    e_rd  = 8'h00;
    for (i = 0; i < 8; i = i + 1) begin
      e_rd[i] = ws[15-i] && (i < nb);
    end
    for (i = 0; i < 16; i = i + 1) begin
      k = 15 - i - sh;
      if ((k >= 0) && (k < 8) && (k < nb)) begin
        w_new[i] = e_in[k];
      end
    end
  end

  wire wr_take = (st_r == S_WR) && (!is_stream || req_take);
  wire wr_done = rem_r <= 16'h0008;
  wire wr_short = is_stream && req_take && i_req_last && !wr_done;

  always @* begin
    st_nxt = st_r;
    case (st_r)
      S_COL: if (req_take && (i_req_last ||
                 (hcnt_r + 4'h1 >= hlen_of((hcnt_r == 4'h0) ? i_req_data : fc)))) begin
               st_nxt = S_CHK;
             end
      S_CHK: if (!o_exchange_on || !sup || vbad || abad || is_rd || (fc == `FC_RD_WR)) begin
               if (!o_exchange_on || !sup || vbad || abad || (fc != `FC_RD_WR)) begin
                 st_nxt = last_r ? ((!o_exchange_on) ? S_COL : S_RSP) : S_DRN;
               end else begin
                 st_nxt = S_WR;
               end
             end else begin
               st_nxt = S_WR;
             end
      S_WR:  if (wr_short) begin
               st_nxt = S_RSP;
             end else if (wr_take && wr_done) begin
               st_nxt = (last_r || (is_stream && i_req_last)) ? S_RSP : S_DRN;
             end
      S_DRN: if (req_take && i_req_last) begin
               st_nxt = silent_r ? S_COL : S_RSP;
             end
      S_RSP: if (rsp_load && (idx_r == rsp_len_r)) begin
               st_nxt = S_COL;
             end
      default: st_nxt = S_COL;
    endcase
  end

  // The buffer is shared with the inside; a server write wins a same-cycle clash.
  always @(posedge i_clk) begin
    if (i_buf_we) begin
      gateway_data_buffer[i_buf_addr] <= i_buf_wdata;
    end
    if (wr_take && !wr_short) begin
      gateway_data_buffer[a0] <= w_new[15:8];
      if ({1'b0, nb} > (5'h08 - {2'b00, sh})) begin
        gateway_data_buffer[a1] <= w_new[7:0];
      end
    end
    o_buf_rdata <= gateway_data_buffer[i_buf_addr];
    if ((st_r == S_COL) && req_take) begin
      hb[hcnt_r] <= i_req_data;
    end
  end

  always @(posedge i_clk) begin
    if (i_reset) begin
      st_r          <= S_COL;
      o_req_ready   <= 1'b1;
      hcnt_r        <= 4'h0;
      last_r        <= 1'b0;
      silent_r      <= 1'b0;
      exc_r         <= 1'b0;
      exc_code_r    <= 8'h00;
      rsp_len_r     <= 9'h000;
      idx_r         <= 9'h000;
      cur_r         <= 22'h00_0000;
      rem_r         <= 16'h0000;
      rd_first_r    <= 22'h00_0000;
      rd_bits_r     <= 16'h0000;
      wk_r          <= 1'b0;
      o_rsp_valid   <= 1'b0;
      o_rsp_data    <= 8'h00;
      o_rsp_last    <= 1'b0;
      o_rsp_conn    <= 3'h0;
      o_std_mode    <= `MODE_FLEX;
      o_exchange_on <= 1'b0;
      o_conn_accept <= 1'b0;
      o_conn_refuse <= 1'b0;
      o_conn_count  <= 4'h0;
    end else begin
      st_r <= st_nxt;
      o_req_ready <= (st_nxt == S_COL) || (st_nxt == S_DRN) || ((st_nxt == S_WR) && is_stream);
      if (i_cfg_wr) begin
        o_std_mode <= i_cfg_std_mode;
      end
      o_exchange_on <= (i_in_size != 10'h000) && (i_out_size != 10'h000);
      o_conn_accept <= i_conn_open && (i_conn_port == `TCP_PORT) && (o_conn_count < MAX_CONN);
      o_conn_refuse <= i_conn_open && !((i_conn_port == `TCP_PORT) && (o_conn_count < MAX_CONN));
      o_conn_count  <= o_conn_count +
                       {3'h0, i_conn_open && (i_conn_port == `TCP_PORT) && (o_conn_count < MAX_CONN)} -
                       {3'h0, i_conn_close && (o_conn_count != 4'h0)};
      if (req_take && i_req_last) begin
        last_r <= 1'b1;
      end
      if ((st_r == S_COL) && req_take) begin
        hcnt_r <= hcnt_r + 4'h1;
        if (hcnt_r == 4'h0) begin
          o_rsp_conn <= i_req_conn;
        end
      end
      if (st_r == S_CHK) begin
        silent_r   <= !o_exchange_on;
        rd_first_r <= rd_first;
        rd_bits_r  <= rd_bits;
        wk_r       <= 1'b0;
        exc_r      <= !sup || vbad || abad;
        rsp_len_r  <= (!sup || vbad || abad) ? 9'h001 : len_ok;
        exc_code_r <= !sup ? `EXC_FUNC : vbad ? `EXC_VALUE : `EXC_ADDR;
        cur_r <= (is_rd && (fc != `FC_RD_WR)) ? rd_first : wr_first;
        rem_r <= (is_rd && (fc != `FC_RD_WR)) ? rd_bits : wr_bits;
      end
      if (wr_take) begin
        wk_r <= 1'b1;
        if (wr_short) begin
          exc_r      <= 1'b1;
          exc_code_r <= `EXC_VALUE;
          rsp_len_r  <= 9'h001;
        end else if (wr_done) begin
          cur_r <= rd_first_r;
          rem_r <= rd_bits_r;
        end else begin
          cur_r <= cur_r + 22'h00_0008;
          rem_r <= rem_r - {12'h000, nb};
        end
      end
      if (rsp_load) begin
        o_rsp_valid <= 1'b1;
        o_rsp_last  <= idx_r == rsp_len_r;
        idx_r       <= (idx_r == rsp_len_r) ? 9'h000 : idx_r + 9'h001;
        if (idx_r == 9'h000) begin
          o_rsp_data <= exc_r ? (fc | `FC_EXC_FLAG) : fc;
        end else if (exc_r) begin
          o_rsp_data <= exc_code_r;
        end else if (!is_rd) begin
          o_rsp_data <= hb[idx_r[3:0]];
        end else if (idx_r == 9'h001) begin
          o_rsp_data <= rsp_len_r[7:0] - 8'h01;
        end else begin
          o_rsp_data <= is_coil ? e_rd : rev8(e_rd);
          cur_r      <= cur_r + 22'h00_0008;
          rem_r      <= rem_r - {12'h000, nb};
        end
        if (idx_r == rsp_len_r) begin
          hcnt_r   <= 4'h0;
          last_r   <= 1'b0;
          silent_r <= 1'b0;
        end
      end else if (o_rsp_valid && i_rsp_ready) begin
        o_rsp_valid <= 1'b0;
        o_rsp_last  <= 1'b0;
      end
      if ((st_r == S_DRN) && (st_nxt == S_COL)) begin
        hcnt_r   <= 4'h0;
        last_r   <= 1'b0;
        silent_r <= 1'b0;
      end
      if ((st_r == S_CHK) && (st_nxt == S_COL)) begin
        hcnt_r <= 4'h0;
        last_r <= 1'b0;
      end
    end
  end

endmodule // modbus_tcp_data_area_server

// file: hw/modbus_server_defines.vh
// Constants for the Modbus-TCP data area server.
`ifndef MODBUS_SERVER_DEFINES_VH
`define MODBUS_SERVER_DEFINES_VH

`define FC_RD_COILS   8'h01
`define FC_RD_DISC    8'h02
`define FC_RD_HOLD    8'h03
`define FC_RD_INPUT   8'h04
`define FC_WR_COIL    8'h05
`define FC_WR_REG     8'h06
`define FC_WR_COILS   8'h0F
`define FC_WR_REGS    8'h10
`define FC_MASK_WR    8'h16
`define FC_RD_WR      8'h17
`define FC_EXC_FLAG   8'h80

`define EXC_FUNC      8'h01
`define EXC_ADDR      8'h02
`define EXC_VALUE     8'h03

`define TCP_PORT      16'h01F6
`define MAX_CONN      4'h8

`define MAX_RD_BITS   16'h07D0
`define MAX_RD_REGS   16'h007D
`define MAX_WR_BITS   16'h0320
`define MAX_WR_REGS   16'h0320
`define MAX_RW_WREGS  16'h0064
`define COIL_ON       16'hFF00

`define HLEN_BASIC    4'h5
`define HLEN_MULTI    4'h6
`define HLEN_MASK     4'h7
`define HLEN_RW       4'hA

`define OUT_BYTE_BASE 19'h0_0800
`define OUT_BIT_BASE  22'h00_4000

`define MODE_FLEX     1'b0
`define MODE_STD      1'b1

`endif

// file: verif/modbus_server_sva.sv
// Port checker for the Modbus-TCP data area server.
`timescale 1ns/1ns
module modbus_server_sva #(
  parameter [3:0] MAX_CONN = 4'h8
) (
  input wire        i_clk,
  input wire        i_reset,
  input wire        i_cfg_wr,
  input wire        i_cfg_std_mode,
  input wire [9:0]  i_in_size,
  input wire [9:0]  i_out_size,
  input wire        i_conn_open,
  input wire [15:0] i_conn_port,
  input wire        o_conn_accept,
  input wire        o_conn_refuse,
  input wire [3:0]  o_conn_count,
  input wire        i_req_valid,
  input wire        i_req_last,
  input wire        o_req_ready,
  input wire        o_rsp_valid,
  input wire [7:0]  o_rsp_data,
  input wire        o_rsp_last,
  input wire        i_rsp_ready,
  input wire        o_std_mode,
  input wire        o_exchange_on
);
  reg req_seen_r;
  reg first_r;
  // A reply may only follow a whole request; first_r marks the opening reply byte.
  always @(posedge i_clk) begin
    if (i_reset) begin
      req_seen_r <= 1'b0;
      first_r    <= 1'b1;
    end else begin
      if (i_req_valid && o_req_ready && i_req_last)
        req_seen_r <= 1'b1;
      else if (o_rsp_valid && i_rsp_ready && o_rsp_last)
        req_seen_r <= 1'b0;
      if (o_rsp_valid && i_rsp_ready)
        first_r <= o_rsp_last;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  sequence exc_head;
    first_r && o_rsp_valid && i_rsp_ready && o_rsp_data[7];
  endsequence
  sequence exc_code;
    o_rsp_valid && i_rsp_ready && o_rsp_last && o_rsp_data inside {8'h01, 8'h02, 8'h03};
  endsequence
  no_unsolicited_a: assert property (o_rsp_valid |-> req_seen_r)
    else $error("reply without a request");
  rsp_hold_a: assert property (o_rsp_valid && !i_rsp_ready |=>
    o_rsp_valid && $stable(o_rsp_data) && $stable(o_rsp_last))
    else $error("reply byte changed while stalled");
  exch_gate_a: assert property (!i_reset |=>
    o_exchange_on == $past(i_in_size != 10'h000 && i_out_size != 10'h000))
    else $error("exchange state does not follow sizes");
  conn_accept_a: assert property (i_conn_open && i_conn_port == 16'h01f6 &&
    o_conn_count < MAX_CONN |=> o_conn_accept && !o_conn_refuse)
    else $error("valid connection not accepted");
  conn_refuse_a: assert property (i_conn_open && (i_conn_port != 16'h01f6 ||
    o_conn_count >= MAX_CONN) |=> o_conn_refuse && !o_conn_accept)
    else $error("invalid connection not refused");
  conn_limit_a: assert property (o_conn_count <= MAX_CONN)
    else $error("too many connections");
  exc_code_a: assert property (exc_head |=> ##[0:8] exc_code)
    else $error("exception reply without a valid code");
  mode_reset_a: assert property ($fell(i_reset) |-> !o_std_mode &&
    o_conn_count == 4'h0 && o_req_ready && !o_rsp_valid)
    else $error("wrong state after reset");
  mode_load_a: assert property (i_cfg_wr |=> o_std_mode == $past(i_cfg_std_mode))
    else $error("mode not loaded");
endmodule // modbus_server_sva

bind modbus_tcp_data_area_server modbus_server_sva #(.MAX_CONN(MAX_CONN)) u_sva (
  .i_clk(i_clk), .i_reset(i_reset), .i_cfg_wr(i_cfg_wr), .i_cfg_std_mode(i_cfg_std_mode),
  .i_in_size(i_in_size), .i_out_size(i_out_size), .i_conn_open(i_conn_open),
  .i_conn_port(i_conn_port), .o_conn_accept(o_conn_accept), .o_conn_refuse(o_conn_refuse),
  .o_conn_count(o_conn_count), .i_req_valid(i_req_valid), .i_req_last(i_req_last),
  .o_req_ready(o_req_ready), .o_rsp_valid(o_rsp_valid), .o_rsp_data(o_rsp_data),
  .o_rsp_last(o_rsp_last), .i_rsp_ready(i_rsp_ready), .o_std_mode(o_std_mode),
  .o_exchange_on(o_exchange_on));

// file: verif/net_master_model.sv
// Behavioural network master that issues request PDUs and gathers replies.
`timescale 1ns/1ns
module net_master_model (
  input  wire       i_clk,
  output reg        o_req_valid,
  output reg  [7:0] o_req_data,
  output reg        o_req_last,
  output reg  [2:0] o_req_conn,
  input  wire       i_req_ready,
  input  wire       i_rsp_valid,
  input  wire [7:0] i_rsp_data,
  input  wire       i_rsp_last,
  output reg        o_rsp_ready
);
  reg [39:0] rsp_acc;
  reg [2:0]  rsp_len;
  reg        rsp_done;
  reg [1:0]  stall_r;
  initial begin
    o_req_valid = 1'b0;
    o_req_data  = 8'h00;
    o_req_last  = 1'b0;
    o_req_conn  = 3'h0;
    o_rsp_ready = 1'b0;
    rsp_acc     = 40'h00_0000_0000;
    rsp_len     = 3'h0;
    rsp_done    = 1'b0;
    stall_r     = 2'h0;
  end
  // Ready drops one cycle in four so that replies must wait like on a busy link.
  always @(posedge i_clk) begin
    stall_r     <= stall_r + 2'h1;
    o_rsp_ready <= (stall_r != 2'h3);
    if (i_rsp_valid && o_rsp_ready) begin
      rsp_acc  <= {rsp_acc[31:0], i_rsp_data};
      rsp_len  <= rsp_len + 3'h1;
      rsp_done <= i_rsp_last;
    end
  end
  task send(input [39:0] pdu, input [2:0] conn);
    integer i;
    rsp_acc  <= 40'h00_0000_0000;
    rsp_len  <= 3'h0;
    rsp_done <= 1'b0;
    o_req_conn <= conn;
    for (i = 0; i < 5; i = i + 1) begin
      o_req_valid <= 1'b1;
      o_req_data  <= pdu[39 - 8 * i -: 8];
      o_req_last  <= (i == 4);
      @(posedge i_clk);
      while (!i_req_ready) @(posedge i_clk);
    end
    // A released data line shows a changed value, not the last byte.
    o_req_valid <= 1'b0;
    o_req_data  <= ~pdu[7:0];
    o_req_last  <= 1'b0;
  endtask
endmodule // net_master_model

// file: verif/tb_top.sv
// Self-checking bench for the Modbus-TCP data area server.
`timescale 1ns/1ns
module tb_top;
  typedef struct packed {
    logic        std;
    logic [39:0] req;
    logic [39:0] rsp;
  } row_t;
  reg         i_clk          = 1'b0;
  reg         i_reset        = 1'b1;
  reg         i_cfg_wr       = 1'b0;
  reg         i_cfg_std_mode = 1'b0;
  reg  [9:0]  i_in_size      = 10'h200;
  reg  [9:0]  i_out_size     = 10'h200;
  reg         i_conn_open    = 1'b0;
  reg  [15:0] i_conn_port    = 16'h01f6;
  reg         i_conn_close   = 1'b0;
  reg         i_buf_we       = 1'b0;
  reg  [9:0]  i_buf_addr     = 10'h000;
  reg  [7:0]  i_buf_wdata    = 8'h00;
  wire        req_valid, req_last, req_ready, rsp_valid, rsp_last, rsp_ready;
  wire [7:0]  req_data, rsp_data, o_buf_rdata;
  wire [2:0]  req_conn, rsp_conn;
  wire [3:0]  o_conn_count;
  wire        o_conn_accept, o_conn_refuse, o_std_mode, o_exchange_on;
  integer     err_total = 0;
  integer     cmp_count = 0;
  integer     i;
  row_t       rows [0:16];
  always #4 i_clk = ~i_clk;
  modbus_tcp_data_area_server #(.MAX_CONN(4'h8)) u_modbus_tcp_data_area_server (
    .i_clk(i_clk), .i_reset(i_reset), .i_cfg_wr(i_cfg_wr), .i_cfg_std_mode(i_cfg_std_mode),
    .i_in_size(i_in_size), .i_out_size(i_out_size), .i_conn_open(i_conn_open),
    .i_conn_port(i_conn_port), .i_conn_close(i_conn_close), .o_conn_accept(o_conn_accept),
    .o_conn_refuse(o_conn_refuse), .o_conn_count(o_conn_count), .i_req_valid(req_valid),
    .i_req_data(req_data), .i_req_last(req_last), .i_req_conn(req_conn),
    .o_req_ready(req_ready), .o_rsp_valid(rsp_valid), .o_rsp_data(rsp_data),
    .o_rsp_last(rsp_last), .o_rsp_conn(rsp_conn), .i_rsp_ready(rsp_ready),
    .i_buf_we(i_buf_we), .i_buf_addr(i_buf_addr), .i_buf_wdata(i_buf_wdata),
    .o_buf_rdata(o_buf_rdata), .o_std_mode(o_std_mode), .o_exchange_on(o_exchange_on));
  net_master_model u_net_master_model (
    .i_clk(i_clk), .o_req_valid(req_valid), .o_req_data(req_data), .o_req_last(req_last),
    .o_req_conn(req_conn), .i_req_ready(req_ready), .i_rsp_valid(rsp_valid),
    .i_rsp_data(rsp_data), .i_rsp_last(rsp_last), .o_rsp_ready(rsp_ready));
  task check(input logic [39:0] seen, input logic [39:0] exp);
    cmp_count = cmp_count + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task give_verdict;
    if (err_total == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task run_req(input [39:0] pdu, input [2:0] conn);
    integer n;
    u_net_master_model.send(pdu, conn);
    n = 0;
    while (!u_net_master_model.rsp_done && n < 60) begin
      @(posedge i_clk);
      n = n + 1;
    end
  endtask
  initial begin
    #100000;
    err_total = err_total + 1;
    give_verdict;
  end
  initial begin
    rows[0]  = '{1'b0, 40'h03_0000_0001, 40'h00_0302_1234};
    rows[1]  = '{1'b0, 40'h04_0400_0001, 40'h00_0402_a50f};
    rows[2]  = '{1'b0, 40'h01_4000_0004, 40'h00_0001_0105};
    rows[3]  = '{1'b0, 40'h05_4004_ff00, 40'h05_4004_ff00};
    rows[4]  = '{1'b0, 40'h03_0400_0001, 40'h00_0302_ad0f};
    rows[5]  = '{1'b0, 40'h02_4000_0005, 40'h00_0002_0115};
    rows[6]  = '{1'b0, 40'h06_0000_1111, 40'h00_0000_8602};
    rows[7]  = '{1'b0, 40'h03_0000_007e, 40'h00_0000_8303};
    rows[8]  = '{1'b0, 40'h03_0100_0001, 40'h00_0000_8302};
    rows[9]  = '{1'b0, 40'h07_0000_0001, 40'h00_0000_8701};
    rows[10] = '{1'b0, 40'h04_0000_0000, 40'h00_0000_8403};
    rows[11] = '{1'b1, 40'h01_0000_0001, 40'h00_0000_8101};
    rows[12] = '{1'b1, 40'h03_0000_0001, 40'h00_0302_ad0f};
    rows[13] = '{1'b1, 40'h04_0000_0001, 40'h00_0402_1234};
    rows[14] = '{1'b1, 40'h03_0100_0001, 40'h00_0000_8302};
    rows[15] = '{1'b1, 40'h06_0001_beef, 40'h06_0001_beef};
    rows[16] = '{1'b1, 40'h03_0001_0001, 40'h00_0302_beef};
    repeat (5) @(posedge i_clk);
    i_reset <= 1'b0;
    // Buffer bytes 0x000, 0x001, 0x200 and 0x201 are filled from the inside.
    for (i = 0; i < 4; i = i + 1) begin
      i_buf_we    <= 1'b1;
      i_buf_addr  <= {i[1], 8'h00, i[0]};
      i_buf_wdata <= 8'h12 + 8'h22 * i + ((i > 1) ? 8'h4f : 8'h00) - ((i == 3) ? 8'hb8 : 8'h00);
      @(posedge i_clk);
    end
    i_buf_we <= 1'b0;
    for (i = 0; i <= 16; i = i + 1) begin
      i_cfg_std_mode <= rows[i].std;
      i_cfg_wr       <= 1'b1;
      @(posedge i_clk);
      i_cfg_wr <= 1'b0;
      @(posedge i_clk);
      check(o_std_mode, rows[i].std);
      run_req(rows[i].req, i[2:0]);
      check(u_net_master_model.rsp_acc, rows[i].rsp);
    end
    i_buf_addr <= 10'h200;
    repeat (2) @(posedge i_clk);
    check(o_buf_rdata, 8'had);
    for (i = 0; i < 10; i = i + 1) begin
      i_conn_open <= 1'b1;
      i_conn_port <= (i == 9) ? 16'h01f7 : 16'h01f6;
      @(posedge i_clk);
      i_conn_open <= 1'b0;
      @(posedge i_clk);
      check({o_conn_accept, o_conn_refuse}, (i < 8) ? 2'b10 : 2'b01);
    end
    check(o_conn_count, 4'h8);
    i_conn_close <= 1'b1;
    @(posedge i_clk);
    i_conn_close <= 1'b0;
    repeat (2) @(posedge i_clk);
    check(o_conn_count, 4'h7);
    i_out_size <= 10'h000;
    repeat (3) @(posedge i_clk);
    check(o_exchange_on, 1'b0);
    run_req(40'h03_0000_0001, 3'h1);
    check(u_net_master_model.rsp_len, 3'h0);
    i_out_size <= 10'h200;
    i_reset    <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_reset <= 1'b0;
    @(posedge i_clk);
    check({o_std_mode, o_conn_count, req_ready}, 6'b000001);
    give_verdict;
  end
endmodule // tb_top
